// >>> hdl/gasr_pkg.sv
// Constants, types and register map of the gauge alert and status register bank
package gasr_pkg;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_VOLT_LIM = 8'h01;
  localparam logic [7:0] OFS_TEMP_LIM = 8'h02;
  localparam logic [7:0] OFS_SALRT = 8'h03;
  localparam logic [7:0] OFS_LOAD_CUR = 8'h04;
  localparam logic [7:0] OFS_QRT0 = 8'h12;
  localparam logic [7:0] OFS_FULLSOC = 8'h13;
  localparam logic [7:0] OFS_DCAP = 8'h18;
  localparam logic [7:0] OFS_CONFIG = 8'h1d;
  // ----------------------------------------
  // Status and configuration bit positions
  // ----------------------------------------
  localparam int ST_BR = 15;
  localparam int ST_SMX = 14;
  localparam int ST_TMX = 13;
  localparam int ST_VMX = 12;
  localparam int ST_BI = 11;
  localparam int ST_SMN = 10;
  localparam int ST_TMN = 9;
  localparam int ST_VMN = 8;
  localparam int ST_DSOC = 7;
  localparam int ST_THM = 6;
  localparam int ST_OCP = 4;
  localparam int ST_BST = 3;
  localparam int ST_POR = 1;
  localparam int CF_SOC_STICKY = 14;
  localparam int CF_TEMP_STICKY = 13;
  localparam int CF_VOLT_STICKY = 12;
  // ----------------------------------------
  // Reset values and disable codes
  // ----------------------------------------
  localparam logic [15:0] RST_VOLT_LIM = 16'hff00;
  localparam logic [15:0] RST_TEMP_LIM = 16'h7f80;
  localparam logic [15:0] RST_SALRT = 16'hff00;
  localparam logic [15:0] RST_FULLSOC = 16'h5f00;
  localparam logic [15:0] RST_DCAP = 16'h0000;
  localparam logic [15:0] RST_CONFIG = 16'h2340;
  localparam logic [15:0] RST_STATUS = 16'h0002;
  localparam logic [7:0] DIS_HI_U = 8'hff;
  localparam logic [7:0] DIS_LO_U = 8'h00;
  localparam logic [7:0] DIS_HI_T = 8'h7f;
  localparam logic [7:0] DIS_LO_T = 8'h80;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [2:0] {
    S_IDLE, S_ADDR, S_PTR, S_WDAT, S_ACK, S_RDAT, S_RACK
  } gasr_state_t;
  typedef struct packed {
    logic [15:0] cell_voltage_result;
    logic [15:0] temperature;
    logic [15:0] soc;
    logic volt_vld;
    logic temp_vld;
    logic soc_vld;
    logic bat_present;
    logic sys_ocp;
    logic thm_hot;
    logic soft_por;
  } gasr_meas_t;
  typedef struct packed {
    logic [15:0] hypothetical_load_current;
    logic [15:0] capacity_correction_entry0;
    logic [15:0] full_charge_soc_threshold;
    logic [15:0] nominal_cell_capacity;
  } gasr_cfg_t;
endpackage : gasr_pkg

// >>> hdl/gasr_alert_cmp.sv
// One threshold pair with its upper and lower alert flags
module gasr_alert_cmp
  import gasr_pkg::*;
#(
  parameter bit SIGNED_CMP = 1'b0,
  parameter logic [7:0] DIS_HI = 8'hff,
  parameter logic [7:0] DIS_LO = 8'h00
) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_strobe,
  input wire logic [7:0] i_value,
  input wire logic [15:0] i_limits,
  input wire logic i_sticky,
  input wire logic i_clr_hi,
  input wire logic i_clr_lo,
  output logic o_hi,
  output logic o_lo
);
  // ----------------------------------------
  // Compare
  // ----------------------------------------
  // Flipping the sign bit makes one unsigned compare serve both kinds
  wire logic [7:0] val_w = {i_value[7] ^ SIGNED_CMP, i_value[6:0]};
  wire logic [7:0] up_w = {i_limits[15] ^ SIGNED_CMP, i_limits[14:8]};
  wire logic [7:0] lo_w = {i_limits[7] ^ SIGNED_CMP, i_limits[6:0]};
  wire logic over_w = (i_limits[15:8] != DIS_HI) && (val_w > up_w);
  wire logic under_w = (i_limits[7:0] != DIS_LO) && (val_w < lo_w);
  wire logic hi_d = i_strobe ? (over_w | (i_sticky & o_hi & ~i_clr_hi)) : (o_hi & ~i_clr_hi);
  wire logic lo_d = i_strobe ? (under_w | (i_sticky & o_lo & ~i_clr_lo)) : (o_lo & ~i_clr_lo);

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_hi <= 1'b0;
      o_lo <= 1'b0;
    end else begin
      o_hi <= hi_d;
      o_lo <= lo_d;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  upper_alert_set_a: assert property (i_strobe && over_w |=> o_hi)
    else $error("upper alert not raised");
  lower_alert_set_a: assert property (i_strobe && under_w |=> o_lo)
    else $error("lower alert not raised");
  self_clear_a: assert property (i_strobe && !i_sticky && !under_w |=> !o_lo)
    else $error("non sticky alert held");
  disabled_low_a: assert property (i_limits[7:0] == DIS_LO && !o_lo |=> !o_lo)
    else $error("disabled lower alert fired");
  sticky_hold_c: cover property (i_sticky && o_hi && i_strobe && !over_w);
endmodule : gasr_alert_cmp

// >>> hdl/gasr_regs.sv
// Gauge alert thresholds, status flags and configuration words behind a two-wire slave
// ----------------------------------------
// ----------------------------------------
module gasr_regs
  import gasr_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h2a // Arbitrary bus address
) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_oe,
  input wire gasr_meas_t i_meas,
  input wire logic i_otp_en,
  input wire logic [15:0] i_otp_full_soc,
  output gasr_cfg_t o_cfg
);
  // ----------------------------------------
  // Pin synchronisers and bus events
  // ----------------------------------------
  logic [1:0] scl_sync_q;
  logic [1:0] sda_sync_q;
  logic scl_p_q;
  logic sda_p_q;
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_sync_q <= {scl_sync_q[0], i_scl};
      sda_sync_q <= {sda_sync_q[0], i_sda};
      scl_p_q <= scl_sync_q[1];
      sda_p_q <= sda_sync_q[1];
    end
  end
  wire logic scl_w = scl_sync_q[1];
  wire logic sda_w = sda_sync_q[1];
  wire logic scl_rise_w = scl_w & ~scl_p_q;
  wire logic scl_fall_w = ~scl_w & scl_p_q;
  wire logic start_w = scl_w & scl_p_q & sda_p_q & ~sda_w;
  wire logic stop_w = scl_w & scl_p_q & ~sda_p_q & sda_w;

  // ----------------------------------------
  // Register storage
  // ----------------------------------------
  logic [15:0] volt_lim_q;
  logic [15:0] temp_lim_q;
  logic [15:0] salrt_q;
  logic [15:0] config_q;
  logic [15:0] stat_q;
  logic [7:0] last_pct_q;
  logic seeded_q;
  logic otp_load_q;
  logic wr_q;
  logic [7:0] wr_addr_q;
  logic [15:0] wr_data_q;
  logic vmx_w;
  logic vmn_w;
  logic tmx_w;
  logic tmn_w;
  logic smx_w;
  logic smn_w;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  wire logic wr_stat_w = wr_q && (wr_addr_q == OFS_STATUS);
  // Software clears by writing 0; a same-cycle event still wins
  wire logic [15:0] clr_w = wr_stat_w ? ~wr_data_q : 16'h0000;
  wire logic [15:0] status_w = {stat_q[15], smx_w, tmx_w, vmx_w, stat_q[11], smn_w, tmn_w,
                                vmn_w, stat_q[7:0]};
  wire logic soc_step_w = i_meas.soc_vld && seeded_q && (i_meas.soc[15:8] != last_pct_q);
  wire logic removed_w = ~i_meas.bat_present & ~stat_q[ST_BST];
  wire logic inserted_w = i_meas.bat_present & stat_q[ST_BST];
  wire logic [15:0] set_w = {removed_w, 3'h0, inserted_w, 3'h0, soc_step_w,
                             i_meas.thm_hot, 1'b0, i_meas.sys_ocp, 2'h0, i_meas.soft_por,
                             1'b0};
  wire logic [15:0] stat_d = {(stat_q[15:4] & ~clr_w[15:4]) | set_w[15:4], ~i_meas.bat_present,
                              (stat_q[2:0] & ~clr_w[2:0]) | set_w[2:0]};
  logic [7:0] ptr_q;
  wire logic [15:0] rd_word_w =
    (ptr_q == OFS_STATUS) ? status_w :
    (ptr_q == OFS_VOLT_LIM) ? volt_lim_q :
    (ptr_q == OFS_TEMP_LIM) ? temp_lim_q :
    (ptr_q == OFS_SALRT) ? salrt_q :
    (ptr_q == OFS_LOAD_CUR) ? o_cfg.hypothetical_load_current :
    (ptr_q == OFS_QRT0) ? o_cfg.capacity_correction_entry0 :
    (ptr_q == OFS_FULLSOC) ? o_cfg.full_charge_soc_threshold :
    (ptr_q == OFS_DCAP) ? o_cfg.nominal_cell_capacity :
    (ptr_q == OFS_CONFIG) ? config_q : 16'h0000;

  // ----------------------------------------
  // Status and SOC step tracking
  // ----------------------------------------
  // Power-up clears flags and sets POR
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      stat_q <= RST_STATUS;
      last_pct_q <= 8'h00;
      seeded_q <= 1'b0;
    end else begin
      stat_q <= stat_d;
      if (i_meas.soc_vld) begin
        last_pct_q <= i_meas.soc[15:8];
        seeded_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Writable registers
  // ----------------------------------------
  // Word registers
  // Full SOC limit from OTP or 95%
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      volt_lim_q <= RST_VOLT_LIM;
      temp_lim_q <= RST_TEMP_LIM;
      salrt_q <= RST_SALRT;
      config_q <= RST_CONFIG;
      o_cfg <= '{16'h0000, 16'h0000, RST_FULLSOC, RST_DCAP};
      otp_load_q <= 1'b1;
    end else begin
      otp_load_q <= 1'b0;
      if (otp_load_q && i_otp_en) begin
        o_cfg.full_charge_soc_threshold <= i_otp_full_soc;
      end
      if (wr_q) begin
        case (wr_addr_q)
          OFS_VOLT_LIM: volt_lim_q <= wr_data_q;
          OFS_TEMP_LIM: temp_lim_q <= wr_data_q;
          OFS_SALRT: salrt_q <= wr_data_q;
          OFS_LOAD_CUR: o_cfg.hypothetical_load_current <= wr_data_q;
          OFS_QRT0: o_cfg.capacity_correction_entry0 <= wr_data_q;
          OFS_FULLSOC: o_cfg.full_charge_soc_threshold <= wr_data_q;
          OFS_DCAP: o_cfg.nominal_cell_capacity <= wr_data_q;
          OFS_CONFIG: config_q <= wr_data_q;
          default: ;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Threshold comparators
  // ----------------------------------------
  // Voltage alerts
  gasr_alert_cmp #(.SIGNED_CMP(1'b0), .DIS_HI(DIS_HI_U), .DIS_LO(DIS_LO_U)) u_volt (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_strobe(i_meas.volt_vld),
    .i_value(i_meas.cell_voltage_result[15:8]),
    .i_limits(volt_lim_q),
    .i_sticky(config_q[CF_VOLT_STICKY]),
    .i_clr_hi(clr_w[ST_VMX]),
    .i_clr_lo(clr_w[ST_VMN]),
    .o_hi(vmx_w),
    .o_lo(vmn_w)
  );
  gasr_alert_cmp #(.SIGNED_CMP(1'b1), .DIS_HI(DIS_HI_T), .DIS_LO(DIS_LO_T)) u_temp (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_strobe(i_meas.temp_vld),
    .i_value(i_meas.temperature[15:8]),
    .i_limits(temp_lim_q),
    .i_sticky(config_q[CF_TEMP_STICKY]),
    .i_clr_hi(clr_w[ST_TMX]),
    .i_clr_lo(clr_w[ST_TMN]),
    .o_hi(tmx_w),
    .o_lo(tmn_w)
  );
  gasr_alert_cmp #(.SIGNED_CMP(1'b0), .DIS_HI(DIS_HI_U), .DIS_LO(DIS_LO_U)) u_soc (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_strobe(i_meas.soc_vld),
    .i_value(i_meas.soc[15:8]),
    .i_limits(salrt_q),
    .i_sticky(config_q[CF_SOC_STICKY]),
    .i_clr_hi(clr_w[ST_SMX]),
    .i_clr_lo(clr_w[ST_SMN]),
    .o_hi(smx_w),
    .o_lo(smn_w)
  );

  // ----------------------------------------
  // Two-wire slave
  // ----------------------------------------
  // Words travel low byte first; high byte is latched so a read is coherent
  gasr_state_t st_q;
  gasr_state_t nxt_q;
  logic [3:0] cnt_q;
  logic [7:0] sr_q;
  logic [7:0] lo_q;
  logic [7:0] tx_q;
  logic [7:0] hi_q;
  logic hi_sel_q;
  logic ack_ok_q;
  wire logic byte_done_w = (cnt_q == BITS_PER_BYTE);
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      st_q <= S_IDLE;
      nxt_q <= S_IDLE;
      cnt_q <= 4'h0;
      sr_q <= 8'h00;
      lo_q <= 8'h00;
      tx_q <= 8'h00;
      hi_q <= 8'h00;
      hi_sel_q <= 1'b0;
      ack_ok_q <= 1'b0;
      ptr_q <= 8'h00;
      o_sda_oe <= 1'b0;
      wr_q <= 1'b0;
      wr_addr_q <= 8'h00;
      wr_data_q <= 16'h0000;
    end else begin
      wr_q <= 1'b0;
      if (start_w) begin
        st_q <= S_ADDR;
        cnt_q <= 4'h0;
        hi_sel_q <= 1'b0;
        o_sda_oe <= 1'b0;
      end else if (stop_w) begin
        st_q <= S_IDLE;
        o_sda_oe <= 1'b0;
      end else begin
        case (st_q)
          S_ADDR, S_PTR, S_WDAT: begin
            if (scl_rise_w) begin
              sr_q <= {sr_q[6:0], sda_w};
              cnt_q <= cnt_q + 4'h1;
            end else if (scl_fall_w && byte_done_w) begin
              cnt_q <= 4'h0;
              st_q <= S_ACK;
              o_sda_oe <= 1'b1;
              nxt_q <= S_WDAT;
              if (st_q == S_ADDR) begin
                nxt_q <= sr_q[0] ? S_RDAT : S_PTR;
                if (sr_q[7:1] != DEV_ADDR) begin
                  st_q <= S_IDLE;
                  o_sda_oe <= 1'b0;
                end
              end else if (st_q == S_PTR) begin
                ptr_q <= sr_q;
              end else begin
                hi_sel_q <= ~hi_sel_q;
                if (!hi_sel_q) begin
                  lo_q <= sr_q;
                end else begin
                  wr_q <= 1'b1;
                  wr_addr_q <= ptr_q;
                  wr_data_q <= {sr_q, lo_q};
                  ptr_q <= ptr_q + 8'h01;
                end
              end
            end
          end
          S_ACK: begin
            if (scl_fall_w) begin
              st_q <= nxt_q;
              o_sda_oe <= 1'b0;
              if (nxt_q == S_RDAT) begin
                tx_q <= rd_word_w[7:0];
                hi_q <= rd_word_w[15:8];
                o_sda_oe <= ~rd_word_w[7];
              end
            end
          end
          S_RDAT: begin
            if (scl_rise_w) begin
              cnt_q <= cnt_q + 4'h1;
            end else if (scl_fall_w) begin
              if (byte_done_w) begin
                o_sda_oe <= 1'b0;
                st_q <= S_RACK;
                cnt_q <= 4'h0;
                if (hi_sel_q) begin
                  ptr_q <= ptr_q + 8'h01;
                end
              end else begin
                tx_q <= {tx_q[6:0], 1'b0};
                o_sda_oe <= ~tx_q[6];
              end
            end
          end
          S_RACK: begin
            if (scl_rise_w) begin
              ack_ok_q <= ~sda_w;
            end else if (scl_fall_w) begin
              st_q <= ack_ok_q ? S_RDAT : S_IDLE;
              hi_sel_q <= ~hi_sel_q;
              if (ack_ok_q && !hi_sel_q) begin
                tx_q <= hi_q;
                o_sda_oe <= ~hi_q[7];
              end else if (ack_ok_q) begin
                tx_q <= rd_word_w[7:0];
                hi_q <= rd_word_w[15:8];
                o_sda_oe <= ~rd_word_w[7];
              end
            end
          end
          default: st_q <= S_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  por_flag_up_a: assert property (!$past(i_rst_n) |-> stat_q[ST_POR])
    else $error("power-on flag not set after reset");
  soft_por_a: assert property (i_meas.soft_por |=> status_w[ST_POR] [*2])
    else $error("software reset flag lost");
  power_up_zero_a: assert property (!$past(i_rst_n) |-> status_w[15:3] == 13'h0)
    else $error("flags not clear at power-up");
  ocp_flag_a: assert property (i_meas.sys_ocp |=> status_w[ST_OCP])
    else $error("overcurrent flag not set");
  bat_level_a: assert property (##1 stat_q[ST_BST] == !$past(i_meas.bat_present))
    else $error("battery status mismatch");
  thm_flag_a: assert property (i_meas.thm_hot |=> stat_q[ST_THM])
    else $error("hot flag not set");
  soc_step_a: assert property (soc_step_w |=> stat_q[ST_DSOC])
    else $error("SOC step flag not set");
  full_soc_rst_a: assert property ($fell(otp_load_q) && !$past(i_otp_en) && !$past(wr_q)
    |-> o_cfg.full_charge_soc_threshold == RST_FULLSOC)
    else $error("full SOC default wrong");
  write_taken_c: cover property (wr_q && wr_addr_q == OFS_VOLT_LIM);
  por_cleared_c: cover property (wr_stat_w ##1 !stat_q[ST_POR]);
  read_word_c: cover property (st_q == S_RACK && ack_ok_q && scl_fall_w);
endmodule : gasr_regs

// >>> testbench/gasr_host_model.sv
// Two-wire bus master standing in for the host processor
module gasr_host_model #(
  parameter logic [6:0] DEV_ADDR = 7'h2a // Arbitrary bus address
) (
  input wire logic i_core_clk,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_low
);
  timeunit 1ns;
  timeprecision 100ps;
  logic ack_seen;
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end
  // Five-cycle phases keep SCL high and low above the four-cycle minimum
  task automatic hw(input int n);
    repeat (n) @(posedge i_core_clk);
    #2;
  endtask : hw
  task automatic start_cond();
    o_sda_low = 1'b0;
    hw(5);
    o_scl = 1'b1;
    hw(5);
    o_sda_low = 1'b1;
    hw(5);
    o_scl = 1'b0;
    hw(2);
  endtask : start_cond
  task automatic stop_cond();
    o_sda_low = 1'b1;
    hw(5);
    o_scl = 1'b1;
    hw(5);
    o_sda_low = 1'b0;
    hw(5);
  endtask : stop_cond
  task automatic wbit(input logic b);
    o_sda_low = !b;
    hw(5);
    o_scl = 1'b1;
    hw(5);
    o_scl = 1'b0;
    hw(1);
  endtask : wbit
  // Released line; the device has about seven cycles after the fall to drive it
  task automatic rbit(output logic b);
    o_sda_low = 1'b0;
    hw(6);
    o_scl = 1'b1;
    hw(3);
    b = i_sda;
    hw(2);
    o_scl = 1'b0;
    hw(1);
  endtask : rbit
  task automatic wbyte(input logic [7:0] d);
    logic a;
    for (int i = 7; i >= 0; i--) wbit(d[i]);
    rbit(a);
    ack_seen = !a;
  endtask : wbyte
  task automatic rbyte(output logic [7:0] d, input logic last);
    for (int i = 7; i >= 0; i--) rbit(d[i]);
    wbit(last);
  endtask : rbyte
  task automatic wr_word(input logic [7:0] ofs, input logic [15:0] d);
    start_cond();
    wbyte({DEV_ADDR, 1'b0});
    wbyte(ofs);
    wbyte(d[7:0]);
    wbyte(d[15:8]);
    stop_cond();
  endtask : wr_word
  task automatic rd_word(input logic [7:0] ofs, output logic [15:0] d);
    start_cond();
    wbyte({DEV_ADDR, 1'b0});
    wbyte(ofs);
    start_cond();
    wbyte({DEV_ADDR, 1'b1});
    rbyte(d[7:0], 1'b0);
    rbyte(d[15:8], 1'b1);
    stop_cond();
  endtask : rd_word
endmodule : gasr_host_model

// >>> testbench/tb.sv
// Self-checking bench for the gauge alert and status register bank
module tb import gasr_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic i_core_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic scl;
  logic sda_low;
  logic o_sda_oe;
  logic sda_wire;
  logic i_otp_en = 1'b0;
  logic [15:0] i_otp_full_soc = 16'h6400;
  gasr_meas_t meas = '0;
  gasr_cfg_t cfg;
  logic [15:0] rdat;
  int n_errors = 0;
  int checked = 0;
  always #25 i_core_clk = ~i_core_clk;
  // Open-drain line with pull-up
  assign sda_wire = !(o_sda_oe || sda_low);
  gasr_regs dut (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_scl(scl), .i_sda(sda_wire),
    .o_sda_oe(o_sda_oe), .i_meas(meas), .i_otp_en(i_otp_en),
    .i_otp_full_soc(i_otp_full_soc), .o_cfg(cfg));
  gasr_host_model host (.i_core_clk(i_core_clk), .i_sda(sda_wire), .o_scl(scl),
    .o_sda_low(sda_low));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic tally_and_finish();
    if (n_errors == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic rchk(input logic [7:0] ofs, input logic [15:0] exp);
    host.rd_word(ofs, rdat);
    chk("ack", 64'h1, {63'h0, host.ack_seen});
    chk($sformatf("reg %h", ofs), {48'h0, exp}, {48'h0, rdat});
  endtask : rchk
  task automatic clk_n(input int n);
    repeat (n) @(posedge i_core_clk);
    #2;
  endtask : clk_n
  // Kind 0 voltage, 1 temperature, 2 SOC; only the strobed word is compared
  task automatic pulse(input int k, input logic [15:0] v);
    meas.cell_voltage_result = v;
    meas.temperature = v;
    meas.soc = v;
    {meas.volt_vld, meas.temp_vld, meas.soc_vld} = 3'b100 >> k;
    clk_n(1);
    {meas.volt_vld, meas.temp_vld, meas.soc_vld} = 3'b000;
    clk_n(2);
  endtask : pulse
  // Kind 0 overcurrent, 1 hot thermistor, 2 soft reset
  task automatic ev(input int k);
    {meas.sys_ocp, meas.thm_hot, meas.soft_por} = 3'b100 >> k;
    clk_n(1);
    {meas.sys_ocp, meas.thm_hot, meas.soft_por} = 3'b000;
    clk_n(2);
  endtask : ev
  task automatic do_reset();
    i_rst_n = 1'b0;
    clk_n(3);
    i_rst_n = 1'b1;
    clk_n(4);
  endtask : do_reset
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    meas.bat_present = 1'b1;
    do_reset();
    rchk(OFS_STATUS, 16'h0002);
    rchk(OFS_VOLT_LIM, 16'hff00);
    rchk(OFS_TEMP_LIM, 16'h7f80);
    rchk(OFS_SALRT, 16'hff00);
    rchk(OFS_CONFIG, 16'h2340);
    chk("full soc", 64'h5f00, {48'h0, cfg.full_charge_soc_threshold});
    host.wr_word(OFS_STATUS, 16'h0000);
    rchk(OFS_STATUS, 16'h0000);
    host.wr_word(OFS_VOLT_LIM, 16'ha064);
    pulse(0, 16'h5000);
    rchk(OFS_STATUS, 16'h0100);
    pulse(0, 16'h6400);
    rchk(OFS_STATUS, 16'h0000);
    pulse(0, 16'hb000);
    rchk(OFS_STATUS, 16'h1000);
    host.wr_word(OFS_VOLT_LIM, 16'hff00);
    pulse(0, 16'h0000);
    rchk(OFS_STATUS, 16'h0000);
    pulse(0, 16'hff00);
    rchk(OFS_STATUS, 16'h0000);
    host.wr_word(OFS_TEMP_LIM, 16'h28f6);
    pulse(1, 16'hf000);
    pulse(1, 16'h1400);
    rchk(OFS_STATUS, 16'h0200);
    host.wr_word(OFS_STATUS, 16'h0000);
    pulse(1, 16'h3000);
    rchk(OFS_STATUS, 16'h2000);
    host.wr_word(OFS_STATUS, 16'h0000);
    host.wr_word(OFS_TEMP_LIM, 16'h7f80);
    pulse(1, 16'h8000);
    pulse(1, 16'h7f00);
    rchk(OFS_STATUS, 16'h0000);
    host.wr_word(OFS_CONFIG, 16'h6340);
    host.wr_word(OFS_SALRT, 16'h5a0a);
    pulse(2, 16'h0500);
    rchk(OFS_STATUS, 16'h0400);
    pulse(2, 16'h0600);
    pulse(2, 16'h3000);
    rchk(OFS_STATUS, 16'h0480);
    host.wr_word(OFS_STATUS, 16'h0000);
    pulse(2, 16'h6000);
    rchk(OFS_STATUS, 16'h4080);
    host.wr_word(OFS_STATUS, 16'h0000);
    ev(0);
    ev(1);
    meas.bat_present = 1'b0;
    clk_n(2);
    rchk(OFS_STATUS, 16'h8058);
    host.wr_word(OFS_STATUS, 16'h0000);
    rchk(OFS_STATUS, 16'h0008);
    meas.bat_present = 1'b1;
    ev(2);
    rchk(OFS_STATUS, 16'h0802);
    host.wr_word(OFS_LOAD_CUR, 16'hfc18);
    host.wr_word(OFS_QRT0, 16'h1234);
    host.wr_word(OFS_FULLSOC, 16'h6000);
    host.wr_word(OFS_DCAP, 16'h0fa0);
    chk("cfg", 64'hfc18_1234_6000_0fa0, cfg);
    rchk(OFS_DCAP, 16'h0fa0);
    rchk(8'h05, 16'h0000);
    // A second reset must also bring every flag back
    i_otp_en = 1'b1;
    do_reset();
    chk("otp cfg", 64'h0000_0000_6400_0000, cfg);
    rchk(OFS_STATUS, 16'h0002);
    tally_and_finish();
  end
  // Tests need about 20000 cycles; the limit of 80000 cycles leaves a wide margin
  initial begin
    #4000000;
    n_errors++;
    tally_and_finish();
  end
endmodule : tb
